// file: mssr_regs.vh
// Register map, field positions and thresholds of the motor stage status registers
`ifndef MSSR_REGS_VH
`define MSSR_REGS_VH

`define MSSR_OFS_STATUS     6'h00
`define MSSR_OFS_SELECT     6'h01
`define MSSR_OFS_VALUE1     6'h02
`define MSSR_OFS_VALUE2     6'h03
`define MSSR_OFS_PAGE       6'h04
`define MSSR_OFS_PRESET     6'h05
`define MSSR_OFS_PAGE_LO    6'h20
`define MSSR_OFS_PAGE_HI    6'h3f

`define MSSR_BIT_FAULT      15
`define MSSR_BIT_NOCTRL     14
`define MSSR_BIT_SHORT      12
`define MSSR_BIT_OVERV      11
`define MSSR_BIT_UNDERV     10
`define MSSR_BIT_OVERC      9
`define MSSR_BIT_OVERT      8
`define MSSR_BIT_SAT        6
`define MSSR_BIT_NEG        5
`define MSSR_BIT_POS        4
`define MSSR_BIT_READY      3
`define MSSR_BIT_ARMABLE    2

`define MSSR_RST_PAGE       16'h0000
`define MSSR_RST_SELECT     16'h0000
`define MSSR_RST_PRESET     16'h0000
`define MSSR_RST_COUNTER    16'h0000

// Voltages in mV, temperatures in degrees C
`define MSSR_CTRL_MIN_MV    16'h2ee0
`define MSSR_SUPPLY_MIN_MV  16'h1f40
`define MSSR_TEMP_WARN_C    16'h0050
`define MSSR_TEMP_ERR_C     16'h0064
`define MSSR_OVER_NUM       20'h0000b
`define MSSR_OVER_DEN       20'h0000a
`define MSSR_UNDER_NUM      20'h00008

// Selection codes; 15 to 254 are reserved and read zero
`define MSSR_SEL_STAT1      8'h00
`define MSSR_SEL_STAT2      8'h01
`define MSSR_SEL_COIL_V1    8'h02
`define MSSR_SEL_COIL_V2    8'h03
`define MSSR_SEL_SUPPLY     8'h04
`define MSSR_SEL_CTRL_V     8'h05
`define MSSR_SEL_COIL_I1    8'h06
`define MSSR_SEL_COIL_I2    8'h07
`define MSSR_SEL_TEMP       8'h08
`define MSSR_SEL_DUTY1      8'h09
`define MSSR_SEL_DUTY2      8'h0a
`define MSSR_SEL_ERR1       8'h0b
`define MSSR_SEL_ERR2       8'h0c
`define MSSR_SEL_LIM1       8'h0d
`define MSSR_SEL_LIM2       8'h0e
`define MSSR_SEL_FW         8'hff
`define MSSR_NSEL           15

`endif

// file: mssr_overload_timer.v
// Overload timer: flags current above rating held longer than the set time
`timescale 1ns/1ps
`include "mssr_regs.vh"

module mssr_overload_timer (
  input  wire        i_clock,
  input  wire        i_rst_n,
  input  wire        i_tick_ms,
  input  wire [15:0] i_current_ma,
  input  wire [15:0] i_rated_ma,
  input  wire [15:0] i_limit_ms,
  output reg         o_overload
);

  reg [15:0] count_q;
  reg        over_q;

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q    <= `MSSR_RST_COUNTER;
      over_q     <= 1'b0;
      o_overload <= 1'b0;
    end else begin
      over_q <= (i_current_ma > i_rated_ma);
      if (!over_q) begin
        count_q <= `MSSR_RST_COUNTER;
      end else if (i_tick_ms && (count_q != 16'hffff)) begin
        count_q <= count_q + 16'h0001;
      end
      o_overload <= over_q && (count_q > i_limit_ms);
    end
  end

endmodule // mssr_overload_timer

// file: mssr_status_registers.v
// Per-channel register bank of a two-channel DC motor output stage
`timescale 1ns/1ps
`include "mssr_regs.vh"

// Function
// - Each motor channel instantiates its own independent copy of this bank.
// - Status bit 14 set while control voltage below 12 V, an error.
// - Status bit 12 set on driver stage short circuit, an error.
// - Status bit 11 warns when supply exceeds nominal by over ten percent.
// - Status bit 10 warns when supply below eighty percent of nominal.
// - Supply below 8 V: undervoltage, fault bit 15, error flag, disable both.
// - Status bit 9 warns when current over rating longer than overload time.
// - Status bit 8 warns when internal temperature above 80 C.
// - Above 100 C: error, fault bit 15, error flag, disable both channels.
// - Status bit 6 warns while the driver stage is saturated.
// - Bit 5 shows negative drive, bit 4 positive drive.
// - Bit 3 shows driver active, bit 2 shows driver ready to activate.
// - Selector low byte picks measured value one, high byte value two.
// - Codes 0-7: status words, coil voltages, supply, control voltage, currents.
// - Codes 8-14: temperature, duty cycles, control errors, current limits.
// - Values in 1 mV, 1 mA, 1 C and 1 percent steps.
// - Code 255 returns driver firmware version; 15 to 254 reserved.
// - Measured value one and two registers show the selected quantities.
// - Page select, reset zero, picks the page shown at numbers 32 to 63.
// - Page 0 is configuration, page 1 read-only measured values.
// - Counter loads the preset on each rising edge of the load trigger bit.
module mssr_status_registers (
  input  wire        i_clock,
  input  wire        i_rst_n,
  // Register communication
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [5:0]  i_reg_addr,
  input  wire [15:0] i_reg_wdata,
  output reg  [15:0] o_reg_rdata,
  output reg         o_reg_ack,
  // Page-0 configuration read back from the configuration store
  input  wire [15:0] i_cfg_rdata,
  input  wire [15:0] i_nominal_supply_voltage_setting,
  input  wire [15:0] i_overload_time_setting,
  input  wire [15:0] i_rated_current_ma,
  input  wire        i_tick_ms,
  // Stage conditions, asynchronous
  input  wire        i_short_circuit,
  input  wire        i_saturated,
  input  wire        i_moving_negative,
  input  wire        i_moving_positive,
  input  wire        i_driver_active,
  input  wire        i_driver_armable_flag,
  input  wire        i_counter_load_trigger_bit,
  // Measurements, same clock domain
  input  wire [15:0] i_other_status,
  input  wire [15:0] i_coil_mv_1,
  input  wire [15:0] i_coil_mv_2,
  input  wire [15:0] i_supply_mv,
  input  wire [15:0] i_control_mv,
  input  wire [15:0] i_coil_ma_1,
  input  wire [15:0] i_coil_ma_2,
  input  wire [15:0] i_temp_c,
  input  wire [15:0] i_duty_pct_1,
  input  wire [15:0] i_duty_pct_2,
  input  wire [15:0] i_ctrl_err_1,
  input  wire [15:0] i_ctrl_err_2,
  input  wire [15:0] i_limit_ma_1,
  input  wire [15:0] i_limit_ma_2,
  input  wire [15:0] i_fw_version,
  input  wire        i_channel_index,
  // Results
  output reg  [15:0] o_channel_status_word,
  output reg         o_status_byte_error_flag,
  output reg         o_disable_channels,
  output reg  [15:0] o_counter,
  output reg  [15:0] o_register_page_select
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam NSYNC = 7;
  wire [NSYNC-1:0] pins_raw;
  reg  [NSYNC-1:0] sync1_q;
  reg  [NSYNC-1:0] sync2_q;
  assign pins_raw = {i_counter_load_trigger_bit, i_driver_armable_flag, i_driver_active,
                     i_moving_positive, i_moving_negative, i_saturated, i_short_circuit};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pins_raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  wire short_s   = sync2_q[0];
  wire sat_s     = sync2_q[1];
  wire neg_s     = sync2_q[2];
  wire pos_s     = sync2_q[3];
  wire active_s  = sync2_q[4];
  wire armable_s = sync2_q[5];
  wire trig_s    = sync2_q[6];

  // ---------------------------------------------------------------
  // Overload timing
  // ---------------------------------------------------------------
  wire overload;
  mssr_overload_timer u_overload (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_tick_ms    (i_tick_ms),
    .i_current_ma (i_channel_index ? i_coil_ma_2 : i_coil_ma_1),
    .i_rated_ma   (i_rated_current_ma),
    .i_limit_ms   (i_overload_time_setting),
    .o_overload   (overload)
  );

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  wire [19:0] supply_x10 = {4'h0, i_supply_mv} * `MSSR_OVER_DEN;
  wire [19:0] nom_x11    = {4'h0, i_nominal_supply_voltage_setting} * `MSSR_OVER_NUM;
  wire [19:0] nom_x8     = {4'h0, i_nominal_supply_voltage_setting} * `MSSR_UNDER_NUM;
  wire no_ctrl   = i_control_mv < `MSSR_CTRL_MIN_MV;
  wire over_v    = supply_x10 > nom_x11;
  wire under_w   = supply_x10 < nom_x8;
  wire under_err = i_supply_mv < `MSSR_SUPPLY_MIN_MV;
  wire temp_w    = i_temp_c > `MSSR_TEMP_WARN_C;
  wire temp_err  = i_temp_c > `MSSR_TEMP_ERR_C;
  wire fatal     = under_err | temp_err;

  reg [15:0] status_d;
  always @* begin
    status_d = 16'h0000;
    status_d[`MSSR_BIT_FAULT]   = fatal | short_s | no_ctrl;
    status_d[`MSSR_BIT_NOCTRL]  = no_ctrl;
    status_d[`MSSR_BIT_SHORT]   = short_s;
    status_d[`MSSR_BIT_OVERV]   = over_v;
    status_d[`MSSR_BIT_UNDERV]  = under_w | under_err;
    status_d[`MSSR_BIT_OVERC]   = overload;
    status_d[`MSSR_BIT_OVERT]   = temp_w;
    status_d[`MSSR_BIT_SAT]     = sat_s;
    status_d[`MSSR_BIT_NEG]     = neg_s;
    status_d[`MSSR_BIT_POS]     = pos_s;
    status_d[`MSSR_BIT_READY]   = active_s;
    status_d[`MSSR_BIT_ARMABLE] = armable_s;
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_channel_status_word    <= 16'h0000;
      o_status_byte_error_flag <= 1'b0;
      o_disable_channels       <= 1'b0;
    end else begin
      o_channel_status_word    <= status_d;
      o_status_byte_error_flag <= status_d[`MSSR_BIT_FAULT];
      o_disable_channels       <= fatal;
    end
  end

  // ---------------------------------------------------------------
  // Measured value selection
  // ---------------------------------------------------------------
  function [15:0] pick;
    input [7:0] code;
    begin
      case (code)
        `MSSR_SEL_STAT1:   pick = i_channel_index ? i_other_status : o_channel_status_word;
        `MSSR_SEL_STAT2:   pick = i_channel_index ? o_channel_status_word : i_other_status;
        `MSSR_SEL_COIL_V1: pick = i_coil_mv_1;
        `MSSR_SEL_COIL_V2: pick = i_coil_mv_2;
        `MSSR_SEL_SUPPLY:  pick = i_supply_mv;
        `MSSR_SEL_CTRL_V:  pick = i_control_mv;
        `MSSR_SEL_COIL_I1: pick = i_coil_ma_1;
        `MSSR_SEL_COIL_I2: pick = i_coil_ma_2;
        `MSSR_SEL_TEMP:    pick = i_temp_c;
        `MSSR_SEL_DUTY1:   pick = i_duty_pct_1;
        `MSSR_SEL_DUTY2:   pick = i_duty_pct_2;
        `MSSR_SEL_ERR1:    pick = i_ctrl_err_1;
        `MSSR_SEL_ERR2:    pick = i_ctrl_err_2;
        `MSSR_SEL_LIM1:    pick = i_limit_ma_1;
        `MSSR_SEL_LIM2:    pick = i_limit_ma_2;
        `MSSR_SEL_FW:      pick = i_fw_version;
        default:           pick = 16'h0000;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Address decoding
  // ---------------------------------------------------------------
  localparam SRC_ZERO = 2'b00;
  localparam SRC_CFG  = 2'b01;
  localparam SRC_MEAS = 2'b10;
  localparam SRC_FW   = 2'b11;
  localparam WR_SEL   = 0;
  localparam WR_PAGE  = 1;
  localparam WR_PRE   = 2;
  localparam NWR      = 3;

  // Source of a read at a number that is not decoded directly
  function [1:0] page_source;
    input [5:0]  addr;
    input [15:0] page;
    begin
      if (addr < `MSSR_OFS_PAGE_LO) begin
        page_source = SRC_ZERO;
      end else if (page == `MSSR_RST_PAGE) begin
        page_source = SRC_CFG;
      end else if (addr == `MSSR_OFS_PAGE_HI) begin
        page_source = SRC_FW;
      end else if ({3'h0, addr[4:0]} < `MSSR_NSEL) begin
        page_source = SRC_MEAS;
      end else begin
        page_source = SRC_ZERO;
      end
    end
  endfunction

  // One-hot write enables; status and value registers stay read-only
  function [NWR-1:0] write_hit;
    input       wr;
    input [5:0] addr;
    begin
      write_hit          = {NWR{1'b0}};
      write_hit[WR_SEL]  = wr && (addr == `MSSR_OFS_SELECT);
      write_hit[WR_PAGE] = wr && (addr == `MSSR_OFS_PAGE);
      write_hit[WR_PRE]  = wr && (addr == `MSSR_OFS_PRESET);
    end
  endfunction

  reg  [15:0]    select_q;
  reg  [15:0]    preset_q;
  reg            trig_q;
  wire [NWR-1:0] wr_hit    = write_hit(i_reg_wr, i_reg_addr);
  wire [1:0]     page_src  = page_source(i_reg_addr, o_register_page_select);
  wire [7:0]     page_code = {3'h0, i_reg_addr[4:0]};
  wire           access    = i_reg_rd | i_reg_wr;

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      select_q <= `MSSR_RST_SELECT;
    end else if (wr_hit[WR_SEL]) begin
      select_q <= i_reg_wdata;
    end
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_register_page_select <= `MSSR_RST_PAGE;
    end else if (wr_hit[WR_PAGE]) begin
      o_register_page_select <= i_reg_wdata;
    end
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      preset_q <= `MSSR_RST_PRESET;
    end else if (wr_hit[WR_PRE]) begin
      preset_q <= i_reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // Edge detector starts low like the idle trigger, so reset gives no false load
  wire trig_rise = trig_s && !trig_q;

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_s;
    end
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_counter <= `MSSR_RST_COUNTER;
    end else if (trig_rise) begin
      o_counter <= preset_q;
    end
  end

  // ---------------------------------------------------------------
  // Register access answers
  // ---------------------------------------------------------------
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_ack <= access;
    end
  end

  // Read data is built at the sampling edge, so the selection function
  // always works on the measurements present at that edge
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `MSSR_OFS_STATUS: o_reg_rdata <= o_channel_status_word;
        `MSSR_OFS_SELECT: o_reg_rdata <= select_q;
        `MSSR_OFS_VALUE1: o_reg_rdata <= pick(select_q[7:0]);
        `MSSR_OFS_VALUE2: o_reg_rdata <= pick(select_q[15:8]);
        `MSSR_OFS_PAGE:   o_reg_rdata <= o_register_page_select;
        `MSSR_OFS_PRESET: o_reg_rdata <= preset_q;
        default: begin
          // Page window and unmapped numbers
          case (page_src)
            SRC_CFG:  o_reg_rdata <= i_cfg_rdata;
            SRC_FW:   o_reg_rdata <= i_fw_version;
            SRC_MEAS: o_reg_rdata <= pick(page_code);
            default:  o_reg_rdata <= 16'h0000;
          endcase
        end
      endcase
    end
  end

endmodule // mssr_status_registers

// file: mssr_status_registers_props.sv
// Concurrent checks on the ports of the motor stage status register bank
`timescale 1ns/1ps
`include "mssr_regs.vh"

module mssr_status_registers_props (
  input wire        i_clock,
  input wire        i_rst_n,
  input wire        i_reg_wr,
  input wire        i_reg_rd,
  input wire [5:0]  i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire [15:0] o_reg_rdata,
  input wire        o_reg_ack,
  input wire [15:0] i_supply_mv,
  input wire [15:0] i_control_mv,
  input wire [15:0] i_temp_c,
  input wire [15:0] i_nominal_supply_voltage_setting,
  input wire [15:0] o_channel_status_word,
  input wire        o_status_byte_error_flag,
  input wire        o_disable_channels,
  input wire [15:0] o_register_page_select
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire [19:0] sup10 = {4'h0, i_supply_mv} * 20'h0000a;
  wire [19:0] nom   = {4'h0, i_nominal_supply_voltage_setting};
  // ------------------------------------------------------------
  // Status word against its measured causes, one edge later
  // ------------------------------------------------------------
  property p_temp; $past(i_rst_n, 2) |->
    o_channel_status_word[8] == ($past(i_temp_c) > `MSSR_TEMP_WARN_C); endproperty
  a_temp: assert property (p_temp) else $error("temperature warning bit wrong");
  property p_ctrl; $past(i_rst_n, 2) |->
    o_channel_status_word[14] == ($past(i_control_mv) < `MSSR_CTRL_MIN_MV); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control power bit wrong");
  property p_ov; $past(i_rst_n, 2) |->
    o_channel_status_word[11] == ($past(sup10) > $past(nom) * `MSSR_OVER_NUM); endproperty
  a_ov: assert property (p_ov) else $error("overvoltage bit wrong");
  property p_uv; $past(i_rst_n, 2) |-> o_channel_status_word[10] ==
    ($past(sup10) < $past(nom) * `MSSR_UNDER_NUM || $past(i_supply_mv) < `MSSR_SUPPLY_MIN_MV);
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage bit wrong");
  property p_dis; $past(i_rst_n, 2) |-> o_disable_channels ==
    ($past(i_supply_mv) < `MSSR_SUPPLY_MIN_MV || $past(i_temp_c) > `MSSR_TEMP_ERR_C); endproperty
  a_dis: assert property (p_dis) else $error("channel disable wrong");
  property p_err; o_disable_channels |-> o_channel_status_word[15] && o_status_byte_error_flag;
  endproperty
  a_err: assert property (p_err) else $error("fault flags missing on disable");
  property p_rsv; o_channel_status_word[13] == 1'b0 && o_channel_status_word[7] == 1'b0 &&
    o_channel_status_word[1:0] == 2'b00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bit set");
  // ------------------------------------------------------------
  // Register access answers
  // ------------------------------------------------------------
  property p_ack; (i_reg_rd || i_reg_wr) |=> o_reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_noack; !(i_reg_rd || i_reg_wr) |=> !o_reg_ack; endproperty
  a_noack: assert property (p_noack) else $error("acknowledge without access");
  property p_hold; !i_reg_rd |=> $stable(o_reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data changed without read");
  property p_page; (i_reg_wr && i_reg_addr == `MSSR_OFS_PAGE) |=>
    o_register_page_select == $past(i_reg_wdata); endproperty
  a_page: assert property (p_page) else $error("page select not written");
  c_dis: cover property (o_disable_channels);
  c_rd1: cover property (i_reg_rd && i_reg_addr == `MSSR_OFS_VALUE1);
  c_ov: cover property (o_channel_status_word[11]);
endmodule // mssr_status_registers_props

bind mssr_status_registers mssr_status_registers_props i_mssr_status_registers_props (
  .i_clock, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
  .o_reg_ack, .i_supply_mv, .i_control_mv, .i_temp_c, .i_nominal_supply_voltage_setting,
  .o_channel_status_word, .o_status_byte_error_flag, .o_disable_channels,
  .o_register_page_select);

// file: mssr_bus_coupler.sv
// Bus coupler model issuing register communication accesses
`timescale 1ns/1ps

module mssr_bus_coupler (
  input  wire        i_clock,
  input  wire [15:0] i_reg_rdata,
  input  wire        i_reg_ack,
  output reg         o_reg_wr,
  output reg         o_reg_rd,
  output reg  [5:0]  o_reg_addr,
  output reg  [15:0] o_reg_wdata
);
  initial begin
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_addr  = 6'h3f;
    o_reg_wdata = 16'hffff;
  end
  // Released lines show the inverse so a stale value is never read as valid
  task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    @(posedge i_clock);
    o_reg_wr    <= wr;
    o_reg_rd    <= !wr;
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    @(posedge i_clock);
    o_reg_wr    <= 1'b0;
    o_reg_rd    <= 1'b0;
    o_reg_addr  <= ~a;
    o_reg_wdata <= ~d;
    @(posedge i_clock);
    ok = (i_reg_ack === 1'b1);
    q  = i_reg_rdata;
  endtask
endmodule // mssr_bus_coupler

// file: testbench.sv
// Self-checking testbench of the motor stage status register bank
`timescale 1ns/1ps
`include "mssr_regs.vh"
`define CHK(got, exp) begin tests_run = tests_run + 1; if ((got) !== (exp)) begin \
  fail_count = fail_count + 1; $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end

module testbench;
  reg         i_clock = 1'b0;
  reg         i_rst_n = 1'b0;
  reg         i_tick_ms = 1'b0;
  reg  [15:0] meas [0:14];
  reg  [15:0] cfg = 16'h5a5a;
  reg  [15:0] fwv = 16'h3141;
  reg  [15:0] nom = 16'h5dc0;
  reg  [5:0]  pins = 6'h00;
  reg         trig = 1'b0;
  reg         chan = 1'b1;
  reg  [53:0] rows [0:6];
  reg  [15:0] q;
  reg         ok;
  wire        wr, rd, ack, err, dis;
  wire [5:0]  addr;
  wire [15:0] wdata, rdata, stat, cnt, page;
  integer     fail_count = 0;
  integer     tests_run = 0;
  integer     k;

  always #50 i_clock = ~i_clock;
  always @(posedge i_clock) i_tick_ms <= ~i_tick_ms;

  mssr_bus_coupler i_mssr_bus_coupler (.i_clock(i_clock), .i_reg_rdata(rdata),
    .i_reg_ack(ack), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata));
  mssr_status_registers i_mssr_status_registers (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_ack(ack), .i_cfg_rdata(cfg),
    .i_nominal_supply_voltage_setting(nom), .i_overload_time_setting(16'h0003),
    .i_rated_current_ma(16'h2000), .i_tick_ms(i_tick_ms), .i_short_circuit(pins[5]),
    .i_saturated(pins[4]), .i_moving_negative(pins[3]), .i_moving_positive(pins[2]),
    .i_driver_active(pins[1]), .i_driver_armable_flag(pins[0]),
    .i_counter_load_trigger_bit(trig), .i_other_status(meas[0]), .i_coil_mv_1(meas[2]),
    .i_coil_mv_2(meas[3]), .i_supply_mv(meas[4]), .i_control_mv(meas[5]),
    .i_coil_ma_1(meas[6]), .i_coil_ma_2(meas[7]), .i_temp_c(meas[8]),
    .i_duty_pct_1(meas[9]), .i_duty_pct_2(meas[10]), .i_ctrl_err_1(meas[11]),
    .i_ctrl_err_2(meas[12]), .i_limit_ma_1(meas[13]), .i_limit_ma_2(meas[14]),
    .i_fw_version(fwv), .i_channel_index(chan), .o_channel_status_word(stat),
    .o_status_byte_error_flag(err), .o_disable_channels(dis), .o_counter(cnt),
    .o_register_page_select(page));

  function [15:0] exp_status(input integer u);
    reg uv8, ot100, nc, ov, uv;
    begin
      uv8   = meas[4] < `MSSR_SUPPLY_MIN_MV;
      ot100 = meas[8] > `MSSR_TEMP_ERR_C;
      nc    = meas[5] < `MSSR_CTRL_MIN_MV;
      ov    = {4'h0, meas[4]} * 20'h0000a > {4'h0, nom} * 20'h0000b;
      uv    = uv8 || {4'h0, meas[4]} * 20'h0000a < {4'h0, nom} * 20'h00008;
      exp_status = {nc | pins[5] | uv8 | ot100, nc, 1'b0, pins[5], ov, uv, 1'b0,
                    meas[8] > `MSSR_TEMP_WARN_C, 1'b0, pins[4:0], 2'b00};
    end
  endfunction
  function [7:0] code_of(input integer n);
    code_of = (n < 16) ? n[7:0] : ((n == 16) ? 8'hfe : 8'hff);
  endfunction
  function [15:0] exp_sel(input [7:0] c);
    exp_sel = (c == 8'h00) ? meas[0] : (c == 8'h01) ? exp_status(0) :
              (c < 8'h0f) ? meas[c[3:0]] : (c == 8'hff) ? fwv : 16'h0000;
  endfunction
  task rdc(input [5:0] a, input [15:0] e);
    begin
      i_mssr_bus_coupler.access(1'b0, a, 16'h0000, q, ok);
      `CHK(ok, 1'b1)
      `CHK(q, e)
    end
  endtask
  task wrt(input [5:0] a, input [15:0] d);
    begin
      i_mssr_bus_coupler.access(1'b1, a, d, q, ok);
      `CHK(ok, 1'b1)
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask

  initial begin
    #2000000;
    fail_count = fail_count + 1;
    close_out;
  end

  initial begin
    for (k = 0; k < 15; k = k + 1) meas[k] = 16'h1000 + k[15:0];
    rows[0] = {16'h5dc0, 16'h5dc0, 16'h0019, 6'b000001};
    rows[1] = {16'h1b58, 16'h5dc0, 16'h0019, 6'b000011};
    rows[2] = {16'h5dc0, 16'h5dc0, 16'h005a, 6'b010110};
    rows[3] = {16'h5dc0, 16'h5dc0, 16'h006e, 6'b001110};
    rows[4] = {16'h6720, 16'h2af8, 16'h0050, 6'b000000};
    rows[5] = {16'h6721, 16'h2ee0, 16'h0051, 6'b100000};
    rows[6] = {16'h4aff, 16'h5dc0, 16'h0064, 6'b000001};
    {meas[4], meas[5], meas[8], pins} = rows[0];
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rdc(`MSSR_OFS_PAGE, 16'h0000);
    rdc(`MSSR_OFS_SELECT, 16'h0000);
    rdc(6'h06, 16'h0000);
    $display("test reset and unmapped read done");
    for (k = 0; k < 7; k = k + 1) begin
      @(posedge i_clock);
      {meas[4], meas[5], meas[8], pins} <= rows[k];
      repeat (5) @(posedge i_clock);
      `CHK(stat, exp_status(0))
      `CHK(dis, (meas[4] < `MSSR_SUPPLY_MIN_MV) || (meas[8] > `MSSR_TEMP_ERR_C))
      `CHK(err, exp_status(0) >> 15)
      wrt(`MSSR_OFS_STATUS, 16'hffff);
      rdc(`MSSR_OFS_STATUS, exp_status(0));
    end
    $display("test status word done");
    for (k = 0; k < 18; k = k + 1) begin
      wrt(`MSSR_OFS_SELECT, {code_of(17 - k), code_of(k)});
      rdc(`MSSR_OFS_VALUE1, exp_sel(code_of(k)));
      rdc(`MSSR_OFS_VALUE2, exp_sel(code_of(17 - k)));
    end
    $display("test measured value selection done");
    chan <= 1'b0;
    wrt(`MSSR_OFS_SELECT, 16'h0100);
    rdc(`MSSR_OFS_VALUE1, exp_status(0));
    rdc(`MSSR_OFS_VALUE2, meas[0]);
    meas[6] <= 16'h2001;
    repeat (3) @(posedge i_clock);
    `CHK(stat[9], 1'b0)
    repeat (20) @(posedge i_clock);
    `CHK(stat[9], 1'b1)
    meas[6] <= 16'h1006;
    repeat (5) @(posedge i_clock);
    `CHK(stat[9], 1'b0)
    chan <= 1'b1;
    $display("test channel index and overload done");
    wrt(`MSSR_OFS_PAGE, 16'h0001);
    rdc(`MSSR_OFS_PAGE, 16'h0001);
    `CHK(page, 16'h0001)
    for (k = 0; k < 15; k = k + 1) rdc(6'h20 + k[5:0], exp_sel(k[7:0]));
    rdc(6'h3f, fwv);
    rdc(6'h2f, 16'h0000);
    wrt(`MSSR_OFS_PAGE, 16'h0000);
    wrt(6'h28, 16'h0f0f);
    rdc(6'h28, cfg);
    $display("test register pages done");
    wrt(`MSSR_OFS_PRESET, 16'h1234);
    @(posedge i_clock);
    trig <= 1'b1;
    repeat (5) @(posedge i_clock);
    `CHK(cnt, 16'h1234)
    wrt(`MSSR_OFS_PRESET, 16'h4321);
    repeat (5) @(posedge i_clock);
    `CHK(cnt, 16'h1234)
    trig <= 1'b0;
    repeat (5) @(posedge i_clock);
    trig <= 1'b1;
    repeat (5) @(posedge i_clock);
    `CHK(cnt, 16'h4321)
    $display("test counter preset done");
    close_out;
  end
endmodule // testbench
